// File: cevc_pkg.sv
package cevc_pkg;

   // Register byte offsets on the Avalon-MM slave.
   localparam int ADDR_W = 6;
   localparam logic [5:0] OFF_UNIT = 6'h00;
   localparam logic [5:0] OFF_EVENT = 6'h04;
   localparam logic [5:0] OFF_CLEAR = 6'h08;
   localparam logic [5:0] OFF_START = 6'h0c;
   localparam logic [5:0] OFF_CMD = 6'h10;
   localparam logic [5:0] OFF_LIVE = 6'h14;
   localparam logic [5:0] OFF_CAPT = 6'h18;
   localparam logic [5:0] OFF_LIMIT = 6'h1c;
   localparam logic [5:0] OFF_STATE = 6'h20;
   localparam logic [5:0] OFF_IRQ_ST = 6'h24;
   localparam logic [5:0] OFF_IRQ_CLR = 6'h28;
   localparam logic [5:0] OFF_IRQ_EN = 6'h2c;

   // Field positions inside the three configuration registers and the command register.
   localparam int SEL_LSB = 0;
   localparam int COND_LSB = 4;
   localparam int CMD_CLEAR_BIT = 0;

   // Values after reset.
   localparam logic [2:0] RST_SEL = 3'h0;
   localparam logic [31:0] RST_LIMIT = 32'hffffffff;
   localparam logic [31:0] RST_COUNT = 32'h00000000;

   // Source input indices on the synchroniser.
   localparam int NUM_SRC = 6;
   localparam int SRC_FRAME = 0;
   localparam int SRC_EXPOSURE = 1;
   localparam int SRC_ROW = 2;
   localparam int SRC_LINK = 3;
   localparam int SRC_EXT = 4;
   localparam int SRC_CAPTURE = 5;

   // Selector codes; zero means Off for every selector.
   localparam logic [2:0] SEL_OFF = 3'h0;
   localparam logic [2:0] SEL_FRAME = 3'h1;
   localparam logic [2:0] SEL_EXPOSURE = 3'h2;
   localparam logic [2:0] SEL_ROW_OR_CAPTURE = 3'h3;
   localparam logic [2:0] SEL_LINK_OR_EXT = 3'h4;
   localparam logic [2:0] SEL_EXT_EVENT = 3'h5;

   // Interrupt status bit positions.
   localparam int IRQ_W = 3;
   localparam int IRQ_DONE = 0;
   localparam int IRQ_CLEAR = 1;
   localparam int IRQ_START = 2;

   typedef enum logic [2:0] {
      COND_EDGE_UP = 3'b000,
      COND_EDGE_DOWN = 3'b001,
      COND_EDGE_BOTH = 3'b010,
      COND_WHILE_HIGH = 3'b011,
      COND_WHILE_LOW = 3'b100
   } cevc_cond_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_ACTIVE = 2'b01,
      ST_DONE = 2'b10
   } cevc_state_t;

endpackage

// File: cevc_src_if.sv
`timescale 1ns/1ns
// Synchronised source levels and their one-cycle edge pulses.
interface cevc_src_if #(parameter int N = 6);
   logic [N-1:0] level;
   logic [N-1:0] rise;
   logic [N-1:0] fall;
   modport drv (output level, output rise, output fall);
   modport use_side (input level, input rise, input fall);
endinterface

// File: cevc_sync.sv
`timescale 1ns/1ns
module cevc_sync #(
   parameter int N = 6
) (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic arst_n,
   // Raw asynchronous source pins.
   input wire logic [N-1:0] raw_in,
   // Synchronised levels and edges.
   cevc_src_if.drv src
);

   logic [N-1:0] meta_reg;
   logic [N-1:0] sync_reg;
   logic [N-1:0] prev_reg;

   // Two-flop synchroniser followed by a previous-value register.
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         meta_reg <= '0;
         sync_reg <= '0;
         prev_reg <= '0;
      end else begin
         meta_reg <= raw_in;
         sync_reg <= meta_reg;
         prev_reg <= sync_reg;
      end
   end

   // Each edge gives a single pulse one cycle wide.
   assign src.level = sync_reg;
   assign src.rise = sync_reg & ~prev_reg;
   assign src.fall = ~sync_reg & prev_reg;

endmodule

// File: cevc_top.sv
`timescale 1ns/1ns
module cevc_top (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic arst_n,
   // Avalon-MM slave.
   input wire logic [5:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Camera source signals.
   input wire logic frame_window,
   input wire logic exposure_window,
   input wire logic row_window,
   input wire logic host_link_trigger,
   input wire logic external_trigger_in,
   input wire logic capture_window,
   // Interrupt.
   output logic irq
);

   cevc_src_if #(.N(cevc_pkg::NUM_SRC)) src ();

   logic [cevc_pkg::NUM_SRC-1:0] raw_src;
   logic [2:0] ev_sel_reg;
   logic count_edge_polarity_reg;
   logic [2:0] clr_sel_reg;
   logic [2:0] clear_condition_reg;
   logic [2:0] st_sel_reg;
   logic [2:0] start_condition_reg;
   logic [31:0] count_limit_reg;
   logic [31:0] live_count_reg;
   logic [31:0] live_count_next;
   logic [31:0] captured_count_reg;
   logic [31:0] captured_count_next;
   cevc_pkg::cevc_state_t state_reg;
   cevc_pkg::cevc_state_t state_next;
   logic hold_reg;
   logic [cevc_pkg::IRQ_W-1:0] irq_status_reg;
   logic [cevc_pkg::IRQ_W-1:0] irq_enable_reg;
   logic [cevc_pkg::IRQ_W-1:0] irq_event;
   logic [31:0] rd_mux;

   // Map a selector code onto one source bit; zero code always reads low.
   function automatic logic pick_src(input logic [5:0] v,
                                     input logic [2:0] code,
                                     input logic evt);
      logic r;
      r = 1'b0;
      case (code)
         cevc_pkg::SEL_FRAME: r = v[cevc_pkg::SRC_FRAME];
         cevc_pkg::SEL_EXPOSURE: r = v[cevc_pkg::SRC_EXPOSURE];
         cevc_pkg::SEL_ROW_OR_CAPTURE:
            r = evt ? v[cevc_pkg::SRC_ROW] : v[cevc_pkg::SRC_CAPTURE];
         cevc_pkg::SEL_LINK_OR_EXT:
            r = evt ? v[cevc_pkg::SRC_LINK] : v[cevc_pkg::SRC_EXT];
         cevc_pkg::SEL_EXT_EVENT: r = evt ? v[cevc_pkg::SRC_EXT] : 1'b0;
         default: r = 1'b0;
      endcase
      return r;
   endfunction

   // Decide whether a condition is met by a level and its edge pulses.
   function automatic logic cond_hit(input logic [2:0] c, input logic lv,
                                     input logic r, input logic f);
      logic h;
      h = 1'b0;
      case (cevc_pkg::cevc_cond_t'(c))
         cevc_pkg::COND_EDGE_UP: h = r;
         cevc_pkg::COND_EDGE_DOWN: h = f;
         cevc_pkg::COND_EDGE_BOTH: h = r | f;
         cevc_pkg::COND_WHILE_HIGH: h = lv;
         cevc_pkg::COND_WHILE_LOW: h = ~lv;
         default: h = 1'b0;
      endcase
      return h;
   endfunction

   // True for the two level conditions.
   function automatic logic is_level(input logic [2:0] c);
      return (c == cevc_pkg::COND_WHILE_HIGH) ||
             (c == cevc_pkg::COND_WHILE_LOW);
   endfunction

   // Merge write data into a register under byte enables.
   function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0] be);
      logic [31:0] m;
      m = old_v;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            m[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return m;
   endfunction

   // Gather the pins; exposure window is high during each exposure.
   assign raw_src[cevc_pkg::SRC_FRAME] = frame_window;
   assign raw_src[cevc_pkg::SRC_EXPOSURE] = exposure_window;
   assign raw_src[cevc_pkg::SRC_ROW] = row_window;
   assign raw_src[cevc_pkg::SRC_LINK] = host_link_trigger;
   assign raw_src[cevc_pkg::SRC_EXT] = external_trigger_in;
   assign raw_src[cevc_pkg::SRC_CAPTURE] = capture_window;

   cevc_sync #(.N(cevc_pkg::NUM_SRC)) u_sync (
      .clk_sys(clk_sys),
      .arst_n(arst_n),
      .raw_in(raw_src),
      .src(src)
   );

   // Bus strobes: a request is taken in the cycle waitrequest is low.
   wire wr_take = avs_write & ~avs_waitrequest;
   wire [5:0] word_addr = {avs_address[5:2], 2'b00};
   wire wr_event = wr_take && word_addr == cevc_pkg::OFF_EVENT;
   wire wr_clear = wr_take && word_addr == cevc_pkg::OFF_CLEAR;
   wire wr_start = wr_take && word_addr == cevc_pkg::OFF_START;
   wire wr_limit = wr_take && word_addr == cevc_pkg::OFF_LIMIT;
   wire wr_irq_clr = wr_take && word_addr == cevc_pkg::OFF_IRQ_CLR;
   wire wr_irq_en = wr_take && word_addr == cevc_pkg::OFF_IRQ_EN;
   wire [31:0] limit_merged = be_merge(count_limit_reg, avs_writedata,
                                       avs_byteenable);
   wire sw_clr = wr_take && word_addr == cevc_pkg::OFF_CMD &&
                 avs_byteenable[0] &&
                 avs_writedata[cevc_pkg::CMD_CLEAR_BIT];

   // Event selection: the chosen edge of the chosen source, Off gives none.
   wire ev_rise = pick_src(src.rise, ev_sel_reg, 1'b1);
   wire ev_fall = pick_src(src.fall, ev_sel_reg, 1'b1);
   wire ev_hit = count_edge_polarity_reg ? ev_fall : ev_rise;

   // Hardware clear selection; Off suppresses it entirely.
   wire clr_on = clr_sel_reg != cevc_pkg::SEL_OFF;
   wire clr_cond = cond_hit(clear_condition_reg,
                            pick_src(src.level, clr_sel_reg, 1'b0),
                            pick_src(src.rise, clr_sel_reg, 1'b0),
                            pick_src(src.fall, clr_sel_reg, 1'b0));
   wire hw_clr = clr_on & clr_cond;

   // Start trigger selection: edges start, levels hold reset.
   wire st_on = st_sel_reg != cevc_pkg::SEL_OFF;
   wire st_lvl = is_level(start_condition_reg);
   wire st_cond = cond_hit(start_condition_reg,
                           pick_src(src.level, st_sel_reg, 1'b0),
                           pick_src(src.rise, st_sel_reg, 1'b0),
                           pick_src(src.fall, st_sel_reg, 1'b0));
   wire start_hold = st_on & st_lvl & st_cond;
   wire start_hit = st_on & ~st_lvl & st_cond;
   wire start_free = ~st_on | st_lvl;
   wire level_clr = start_hold | (hw_clr & is_level(clear_condition_reg));
   wire zero_any = start_hold | sw_clr | hw_clr |
                   (start_hit & (state_reg != cevc_pkg::ST_ACTIVE));
   wire capture = zero_any & ~hold_reg;
   wire [31:0] count_inc = live_count_reg + 32'h00000001;

   // Counter state machine; hold, then clears, then start, then counting.
   always_comb begin
      state_next = state_reg;
      live_count_next = live_count_reg;
      if (start_hold) begin
         state_next = cevc_pkg::ST_IDLE;
         live_count_next = cevc_pkg::RST_COUNT;
      end else if (sw_clr) begin
         state_next = cevc_pkg::ST_ACTIVE;
         live_count_next = cevc_pkg::RST_COUNT;
      end else if (hw_clr) begin
         live_count_next = cevc_pkg::RST_COUNT;
         if (state_reg == cevc_pkg::ST_DONE) state_next = cevc_pkg::ST_ACTIVE;
      end else if (start_hit && state_reg != cevc_pkg::ST_ACTIVE) begin
         state_next = cevc_pkg::ST_ACTIVE;
         live_count_next = cevc_pkg::RST_COUNT;
      end else begin
         case (state_reg)
            cevc_pkg::ST_IDLE:
               if (start_free) state_next = cevc_pkg::ST_ACTIVE;
            cevc_pkg::ST_ACTIVE: begin
               if (live_count_reg >= count_limit_reg) begin
                  state_next = cevc_pkg::ST_DONE;
               end else if (ev_hit) begin
                  live_count_next = count_inc;
                  if (count_inc >= count_limit_reg) begin
                     state_next = cevc_pkg::ST_DONE;
                  end
               end
            end
            cevc_pkg::ST_DONE: state_next = cevc_pkg::ST_DONE;
            default: state_next = cevc_pkg::ST_IDLE;
         endcase
      end
   end

   assign captured_count_next = capture ? live_count_reg : captured_count_reg;

   // Interrupt events: reaching the limit, a clear, an accepted start.
   assign irq_event[cevc_pkg::IRQ_DONE] =
      (state_next == cevc_pkg::ST_DONE) && (state_reg != cevc_pkg::ST_DONE);
   assign irq_event[cevc_pkg::IRQ_CLEAR] = capture;
   assign irq_event[cevc_pkg::IRQ_START] =
      start_hit && (state_reg != cevc_pkg::ST_ACTIVE);

   // Counter registers.
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         state_reg <= cevc_pkg::ST_IDLE;
         live_count_reg <= cevc_pkg::RST_COUNT;
         captured_count_reg <= cevc_pkg::RST_COUNT;
         hold_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         live_count_reg <= live_count_next;
         captured_count_reg <= captured_count_next;
         hold_reg <= level_clr;
      end
   end

   // Configuration registers written by software.
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         ev_sel_reg <= cevc_pkg::RST_SEL;
         count_edge_polarity_reg <= 1'b0;
         clr_sel_reg <= cevc_pkg::RST_SEL;
         clear_condition_reg <= 3'h0;
         st_sel_reg <= cevc_pkg::RST_SEL;
         start_condition_reg <= 3'h0;
         count_limit_reg <= cevc_pkg::RST_LIMIT;
         irq_enable_reg <= '0;
      end else begin
         if (wr_event && avs_byteenable[0]) begin
            ev_sel_reg <= avs_writedata[cevc_pkg::SEL_LSB +: 3];
            count_edge_polarity_reg <= avs_writedata[cevc_pkg::COND_LSB];
         end
         if (wr_clear && avs_byteenable[0]) begin
            clr_sel_reg <= avs_writedata[cevc_pkg::SEL_LSB +: 3];
            clear_condition_reg <= avs_writedata[cevc_pkg::COND_LSB +: 3];
         end
         if (wr_start && avs_byteenable[0]) begin
            st_sel_reg <= avs_writedata[cevc_pkg::SEL_LSB +: 3];
            start_condition_reg <= avs_writedata[cevc_pkg::COND_LSB +: 3];
         end
         if (wr_limit && limit_merged != 32'h00000000) begin
            count_limit_reg <= limit_merged;
         end
         if (wr_irq_en && avs_byteenable[0]) begin
            irq_enable_reg <= avs_writedata[cevc_pkg::IRQ_W-1:0];
         end
      end
   end

   // Sticky status: a new event wins over a clear in the same cycle.
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         irq_status_reg <= '0;
         irq <= 1'b0;
      end else begin
         irq_status_reg <= irq_event | (irq_status_reg &
            ~((wr_irq_clr && avs_byteenable[0]) ?
              avs_writedata[cevc_pkg::IRQ_W-1:0] : '0));
         irq <= |(irq_status_reg & irq_enable_reg);
      end
   end

   // Read selection; unmapped and write-only words read as zero.
   always_comb begin
      rd_mux = 32'h00000000;
      case (word_addr)
         cevc_pkg::OFF_UNIT: rd_mux = 32'h00000000;
         cevc_pkg::OFF_EVENT: rd_mux = {24'h000000, 3'h0,
            count_edge_polarity_reg, 1'b0, ev_sel_reg};
         cevc_pkg::OFF_CLEAR: rd_mux = {25'h0, clear_condition_reg,
            1'b0, clr_sel_reg};
         cevc_pkg::OFF_START: rd_mux = {25'h0, start_condition_reg,
            1'b0, st_sel_reg};
         cevc_pkg::OFF_LIVE: rd_mux = live_count_reg;
         cevc_pkg::OFF_CAPT: rd_mux = captured_count_reg;
         cevc_pkg::OFF_LIMIT: rd_mux = count_limit_reg;
         cevc_pkg::OFF_STATE: rd_mux = {29'h0, hold_reg, state_reg};
         cevc_pkg::OFF_IRQ_ST: rd_mux = {29'h0, irq_status_reg};
         cevc_pkg::OFF_IRQ_EN: rd_mux = {29'h0, irq_enable_reg};
         default: rd_mux = 32'h00000000;
      endcase
   end

   // One wait cycle per request; read data is loaded before it is taken.
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         avs_waitrequest <= 1'b1;
         avs_readdata <= 32'h00000000;
      end else begin
         avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
         if (avs_read && avs_waitrequest) begin
            avs_readdata <= rd_mux;
         end
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!arst_n);
   unit_read_a: assert property (
      (avs_read && avs_waitrequest && word_addr == cevc_pkg::OFF_UNIT)
      |=> avs_readdata == 32'h00000000)
      else $error("unit selector read back nonzero");
   count_step_a: assert property (
      (state_reg == cevc_pkg::ST_ACTIVE && ev_hit && !zero_any &&
       live_count_reg < count_limit_reg)
      |=> live_count_reg == $past(live_count_reg) + 32'h00000001)
      else $error("counter did not advance on event edge");
   source_off_a: assert property (
      (ev_sel_reg == cevc_pkg::SEL_OFF && !zero_any)
      |=> $stable(live_count_reg))
      else $error("count moved with event source off");
   clear_off_a: assert property (
      (clr_sel_reg == cevc_pkg::SEL_OFF && !(start_hold | sw_clr | start_hit))
      |=> $stable(captured_count_reg))
      else $error("capture taken with clear source off");
   hw_clear_a: assert property (
      (hw_clr && !start_hold) |=> live_count_reg == 32'h00000000)
      else $error("hardware clear did not zero the count");
   sw_clear_a: assert property (
      (sw_clr && !start_hold) |=>
      (live_count_reg == 32'h00000000 && state_reg == cevc_pkg::ST_ACTIVE))
      else $error("software clear did not restart");
   live_read_a: assert property (
      (avs_read && avs_waitrequest && word_addr == cevc_pkg::OFF_LIVE)
      |=> avs_readdata == $past(live_count_reg))
      else $error("live count read mismatch");
   capture_val_a: assert property (
      capture |=> captured_count_reg == $past(live_count_reg))
      else $error("captured count is not the pre-clear value");
   limit_stop_a: assert property (
      (state_reg == cevc_pkg::ST_DONE && !zero_any)
      |=> $stable(live_count_reg) && state_reg == cevc_pkg::ST_DONE)
      else $error("counter moved after reaching the limit");
   start_hold_a: assert property (
      start_hold |=> (live_count_reg == 32'h00000000 &&
                      state_reg == cevc_pkg::ST_IDLE))
      else $error("start level did not hold the counter reset");
   wait_once_a: assert property (
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("waitrequest held beyond one cycle");
   done_cov: cover property (state_reg == cevc_pkg::ST_ACTIVE ##1
                             state_reg == cevc_pkg::ST_DONE);
   hw_clear_cov: cover property (hw_clr && live_count_reg != 32'h00000000);
   start_cov: cover property (start_hit && state_reg == cevc_pkg::ST_IDLE);
   irq_cov: cover property (irq);

endmodule

// File: cevc_cam_model.sv
`timescale 1ns/1ns
module cevc_cam_model (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic arst_n,
   // Pulse request and held levels from the bench.
   input wire logic go,
   input wire logic [2:0] which,
   input wire logic [7:0] count,
   input wire logic [5:0] hold,
   // Source levels and status.
   output logic [5:0] src,
   output logic busy
);
   logic [7:0] left_reg;
   logic [2:0] phase_reg;
   logic [2:0] idx_reg;
   // Each pulse is high four cycles and low four, so the sync stages see it.
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         left_reg <= 8'h00;
         phase_reg <= 3'h0;
         idx_reg <= 3'h0;
      end else if (go && !busy) begin
         left_reg <= count;
         idx_reg <= which;
         phase_reg <= 3'h0;
      end else if (busy) begin
         phase_reg <= phase_reg + 3'h1;
         if (phase_reg == 3'h7) left_reg <= left_reg - 8'h01;
      end
   end
   // A window is high for the first half of each period, then released.
   assign busy = left_reg != 8'h00;
   assign src = hold |
      ((busy && !phase_reg[2]) ? 6'h01 << idx_reg : 6'h00);
endmodule

// File: testbench.sv
`timescale 1ns/1ns
module testbench;
   logic clk_sys, arst_n, rd_s, wr_s, go, wq, irq;
   logic [5:0] addr, src, hold;
   logic [31:0] wdata, rdata, r;
   logic [2:0] which;
   logic [7:0] cnt;
   logic busy;
   int n_errors = 0, total_checks = 0, cycles = 0;
   int cidx[4] = '{0, 1, 5, 4};
   // Design under test with the camera model on its source pins.
   cevc_top uut (.clk_sys(clk_sys), .arst_n(arst_n), .avs_address(addr),
      .avs_read(rd_s), .avs_write(wr_s), .avs_writedata(wdata),
      .avs_byteenable(4'hf), .avs_readdata(rdata), .avs_waitrequest(wq),
      .frame_window(src[0]), .exposure_window(src[1]), .row_window(src[2]),
      .host_link_trigger(src[3]), .external_trigger_in(src[4]),
      .capture_window(src[5]), .irq(irq));
   cevc_cam_model cam (.clk_sys(clk_sys), .arst_n(arst_n), .go(go),
      .which(which), .count(cnt), .hold(hold), .src(src), .busy(busy));
   // Clock of 20 ns period.
   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end
   // Prints the counts and the verdict, then stops.
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // Cuts a hang short.
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 20000) begin
         n_errors++;
         end_of_test();
      end
   end
   // Holds one bus request until waitrequest is sampled low.
   task automatic bus(input logic w, input logic [5:0] a,
                      input logic [31:0] d);
      @(posedge clk_sys);
      rd_s <= !w;
      wr_s <= w;
      addr <= a;
      wdata <= d;
      do @(posedge clk_sys); while (wq !== 1'b0);
      r = rdata;
      rd_s <= 1'b0;
      wr_s <= 1'b0;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic rchk(input logic [5:0] a, input logic [31:0] e,
                       input logic [31:0] m = 32'hffffffff);
      bus(1'b0, a, 32'h0);
      check(r & m, e);
   endtask
   // Sends n pulses on one source and lets them pass the synchroniser.
   task automatic pulse(input logic [2:0] w, input logic [7:0] n);
      @(posedge clk_sys);
      go <= 1'b1;
      which <= w;
      cnt <= n;
      @(posedge clk_sys);
      go <= 1'b0;
      @(posedge clk_sys);
      while (busy === 1'b1) @(posedge clk_sys);
      repeat (6) @(posedge clk_sys);
   endtask
   task automatic hold_set(input logic [5:0] h);
      @(posedge clk_sys);
      hold <= h;
      repeat (8) @(posedge clk_sys);
   endtask
   // Main sequence.
   initial begin
      arst_n = 1'b0;
      rd_s = 1'b0;
      wr_s = 1'b0;
      go = 1'b0;
      hold = 6'h00;
      addr = 6'h00;
      wdata = 32'h0;
      which = 3'h0;
      cnt = 8'h00;
      repeat (5) @(posedge clk_sys);
      arst_n <= 1'b1;
      bus(1'b1, cevc_pkg::OFF_UNIT, 32'h5);
      rchk(cevc_pkg::OFF_UNIT, 32'h0);
      rchk(cevc_pkg::OFF_LIMIT, 32'hffffffff);
      rchk(cevc_pkg::OFF_STATE, 32'h1, 32'h3);
      rchk(6'h3c, 32'h0);
      $display("reset values done");
      for (int i = 1; i <= 5; i++) begin
         bus(1'b1, cevc_pkg::OFF_CMD, 32'h1);
         bus(1'b1, cevc_pkg::OFF_EVENT, i);
         pulse(3'(i - 1), 8'h02);
         rchk(cevc_pkg::OFF_LIVE, 32'h2);
      end
      bus(1'b1, cevc_pkg::OFF_CMD, 32'h1);
      rchk(cevc_pkg::OFF_CAPT, 32'h2);
      bus(1'b1, cevc_pkg::OFF_EVENT, 32'h11);
      pulse(3'h0, 8'h03);
      hold_set(6'h01);
      rchk(cevc_pkg::OFF_LIVE, 32'h3);
      hold_set(6'h00);
      rchk(cevc_pkg::OFF_LIVE, 32'h4);
      bus(1'b1, cevc_pkg::OFF_EVENT, 32'h0);
      pulse(3'h4, 8'h02);
      rchk(cevc_pkg::OFF_LIVE, 32'h4);
      $display("event sources done");
      bus(1'b1, cevc_pkg::OFF_LIMIT, 32'h3);
      bus(1'b1, cevc_pkg::OFF_IRQ_EN, 32'h0);
      bus(1'b1, cevc_pkg::OFF_EVENT, 32'h5);
      bus(1'b1, cevc_pkg::OFF_CMD, 32'h1);
      pulse(3'h4, 8'h05);
      rchk(cevc_pkg::OFF_LIVE, 32'h3);
      rchk(cevc_pkg::OFF_STATE, 32'h2, 32'h3);
      check({31'h0, irq}, 32'h0);
      bus(1'b1, cevc_pkg::OFF_IRQ_EN, 32'h1);
      rchk(cevc_pkg::OFF_IRQ_ST, 32'h1, 32'h1);
      check({31'h0, irq}, 32'h1);
      bus(1'b1, cevc_pkg::OFF_IRQ_CLR, 32'h7);
      rchk(cevc_pkg::OFF_IRQ_ST, 32'h0, 32'h1);
      check({31'h0, irq}, 32'h0);
      $display("limit and interrupt done");
      for (int i = 1; i <= 4; i++) begin
         bus(1'b1, cevc_pkg::OFF_CLEAR, 32'h0);
         bus(1'b1, cevc_pkg::OFF_CMD, 32'h1);
         pulse(3'h4, 8'h01);
         bus(1'b1, cevc_pkg::OFF_CLEAR, 32'h20 | i);
         pulse(3'(cidx[i - 1]), 8'h01);
         rchk(cevc_pkg::OFF_LIVE, 32'h0);
      end
      bus(1'b1, cevc_pkg::OFF_CLEAR, 32'h31);
      pulse(3'h4, 8'h01);
      hold_set(6'h01);
      rchk(cevc_pkg::OFF_CAPT, 32'h1);
      pulse(3'h4, 8'h02);
      rchk(cevc_pkg::OFF_LIVE, 32'h0);
      hold_set(6'h00);
      bus(1'b1, cevc_pkg::OFF_CLEAR, 32'h0);
      pulse(3'h4, 8'h01);
      pulse(3'h0, 8'h01);
      rchk(cevc_pkg::OFF_LIVE, 32'h1);
      $display("hardware clear done");
      bus(1'b1, cevc_pkg::OFF_START, 32'h32);
      hold_set(6'h02);
      pulse(3'h4, 8'h02);
      rchk(cevc_pkg::OFF_LIVE, 32'h0);
      rchk(cevc_pkg::OFF_STATE, 32'h4, 32'h7);
      hold_set(6'h00);
      bus(1'b1, cevc_pkg::OFF_START, 32'h02);
      pulse(3'h4, 8'h03);
      rchk(cevc_pkg::OFF_STATE, 32'h2, 32'h3);
      pulse(3'h1, 8'h01);
      rchk(cevc_pkg::OFF_STATE, 32'h1, 32'h3);
      rchk(cevc_pkg::OFF_LIVE, 32'h0);
      rchk(cevc_pkg::OFF_IRQ_ST, 32'h6, 32'h6);
      $display("start trigger done");
      end_of_test();
   end
endmodule
